/* pkg/srs_pkg.sv */
// package: constants, types and helpers of the serial register access sequencer
package srs_pkg;

  localparam int          CMD_W         = 8;
  localparam int          WIDE_W        = 24;
  localparam int          NARROW_DATA_W = 16;
  localparam int          CNT_W         = 6;
  localparam logic [5:0]  QUIET_EDGES   = 6'h20;
  localparam int          FHI_WL_BIT    = 6;

  localparam logic [2:0]  RS_CMD  = 3'h0;
  localparam logic [2:0]  RS_MODE = 3'h1;
  localparam logic [2:0]  RS_FHI  = 3'h2;
  localparam logic [2:0]  RS_FLO  = 3'h3;
  localparam logic [2:0]  RS_TEST = 3'h4;
  localparam logic [2:0]  RS_DATA = 3'h5;
  localparam logic [2:0]  RS_ZERO = 3'h6;
  localparam logic [2:0]  RS_FULL = 3'h7;

  localparam logic [6:0]  CMD_RESET  = 7'h04;
  localparam logic [7:0]  MODE_RESET = 8'h00;
  localparam logic [7:0]  FHI_RESET  = 8'h00;
  localparam logic [7:0]  FLO_RESET  = 8'h00;
  localparam logic [7:0]  TEST_RESET = 8'h00;
  localparam logic [23:0] DATA_RESET = 24'h000000;

  localparam int          AV_ADDR_W = 4;
  localparam logic [3:0]  AV_STATUS = 4'h0;
  localparam logic [3:0]  AV_CONV   = 4'h4;
  localparam logic [3:0]  AV_CONFIG = 4'h8;

  typedef enum logic [1:0] {ST_CMD, ST_LOAD, ST_WRITE, ST_READ} srs_state_t;

  typedef struct packed {
    logic [2:0] sel;
    logic       rd;
    logic [2:0] chan;
  } srs_cmd_t;

  typedef struct packed {
    logic [AV_ADDR_W-1:0] addr;
    logic                 rd;
    logic                 wr;
    logic [31:0]          wdata;
    logic [3:0]           be;
  } srs_avreq_t;

  // channels share calibration pairs; test channel uses pair 2
  function automatic logic [1:0] cal_pair(input logic [2:0] chan);
    unique case (chan)
      3'h0, 3'h4: cal_pair = 2'h0;
      3'h1, 3'h5: cal_pair = 2'h1;
      default:    cal_pair = 2'h2;
    endcase
  endfunction : cal_pair

  function automatic logic [5:0] reg_width(input logic [2:0] sel, input logic wl24);
    if (sel == RS_DATA)
      reg_width = wl24 ? 6'(WIDE_W) : 6'(NARROW_DATA_W);
    else if (sel > RS_DATA)
      reg_width = 6'(WIDE_W);
    else
      reg_width = 6'(CMD_W);
  endfunction : reg_width

endpackage : srs_pkg

/* rtl/srs_pin_sync.sv */
// module: two-flop synchroniser with edge detection for serial pins
`timescale 1ns/10ps
module srs_pin_sync #(
  parameter int W = 2
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;

  initial if (W < 1) $error("srs_pin_sync: W must be at least 1");

  // pins idle high; edges come only from the second and third stages
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      meta_q <= '1;
      sync_q <= '1;
      last_q <= '1;
    end
    else
    begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise  = sync_q & ~last_q;
  assign o_fall  = ~sync_q & last_q;
endmodule : srs_pin_sync

/* rtl/srs_cal_mem.sv */
// module: calibration coefficient store, zero and full scale per channel pair
`timescale 1ns/10ps
module srs_cal_mem #(
  parameter int PAIRS = 3,
  parameter int W     = 24
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_reset,
  input  wire logic         i_wr,
  input  wire logic         i_full,
  input  wire logic [1:0]   i_pair,
  input  wire logic [W-1:0] i_wdata,
  output logic      [W-1:0] o_zero,
  output logic      [W-1:0] o_fullv
);
  logic [W-1:0] zero_q [PAIRS];
  logic [W-1:0] full_q [PAIRS];
  logic [W-1:0] zero_rd_q;
  logic [W-1:0] full_rd_q;

  initial if (PAIRS < 1 || PAIRS > 4) $error("srs_cal_mem: PAIRS must be 1 to 4");

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      for (int i = 0; i < PAIRS; i++)
      begin
        zero_q[i] <= '0;
        full_q[i] <= '0;
      end
      zero_rd_q <= '0;
      full_rd_q <= '0;
    end
    else
    begin
      if (i_wr && !i_full)
        zero_q[i_pair] <= i_wdata;
      if (i_wr && i_full)
        full_q[i_pair] <= i_wdata;
      zero_rd_q <= zero_q[i_pair];
      full_rd_q <= full_q[i_pair];
    end
  end

  assign o_zero  = zero_rd_q;
  assign o_fullv = full_rd_q;
endmodule : srs_cal_mem

/* rtl/srs_seq.sv */
// module: serial register access sequencer with avalon-mm side port
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
module srs_seq (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_reset,
  input  wire logic                          i_sclk,
  input  wire logic                          i_din,
  output logic                               o_dout,
  output logic                               o_conversion_ready_low,
  output logic [2:0]                         o_input_channel_select,
  input  wire logic [srs_pkg::AV_ADDR_W-1:0] i_avs_address,
  input  wire logic                          i_avs_read,
  input  wire logic                          i_avs_write,
  input  wire logic [31:0]                   i_avs_writedata,
  input  wire logic [3:0]                    i_avs_byteenable,
  output logic [31:0]                        o_avs_readdata,
  output logic                               o_avs_waitrequest
);
  srs_pkg::srs_state_t   state_q, state_d;
  srs_pkg::srs_cmd_t     cmd_q, cmd_d;
  srs_pkg::srs_avreq_t   req;
  logic [5:0]            cnt_q, cnt_d;
  logic [5:0]            ones_q, ones_d;
  logic [23:0]           sh_q, sh_d;
  logic                  dout_q, dout_d;
  logic                  rdy_low_q, rdy_low_d;
  logic [7:0]            mode_q, mode_d;
  logic [7:0]            fhi_q, fhi_d;
  logic [7:0]            flo_q, flo_d;
  logic [7:0]            test_q, test_d;
  logic [23:0]           data_q, data_d;
  logic                  wait_q, wait_d;
  logic [31:0]           rdata_q, rdata_d;
  logic [1:0]            pin_level;
  logic [1:0]            pin_rise;
  logic [1:0]            pin_fall;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  din;
  logic                  cal_wr;
  logic [23:0]           cal_zero;
  logic [23:0]           cal_full;
  logic [5:0]            width;
  logic                  conv_wr;
  logic                  data_read_done;

  srs_pin_sync #(
    .W (2)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_pin     ({i_din, i_sclk}),
    .o_level   (pin_level),
    .o_rise    (pin_rise),
    .o_fall    (pin_fall)
  );

  assign sclk_rise = pin_rise[0];
  assign sclk_fall = pin_fall[0];
  assign din       = pin_level[1];

  // read port follows the next command, so the load cycle already sees the new pair
  srs_cal_mem #(
    .PAIRS (3),
    .W     (24)
  ) u_cal (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_wr      (cal_wr),
    .i_full    (cmd_q.sel == srs_pkg::RS_FULL),
    .i_pair    (srs_pkg::cal_pair(cmd_d.chan)),
    .i_wdata   (sh_d),
    .o_zero    (cal_zero),
    .o_fullv   (cal_full)
  );

  // word length bit picks the 16 or 24 bit data register width
  assign width = srs_pkg::reg_width(cmd_q.sel, fhi_q[srs_pkg::FHI_WL_BIT]);

  assign req = '{addr: i_avs_address, rd: i_avs_read, wr: i_avs_write,
                 wdata: i_avs_writedata, be: i_avs_byteenable};

  // serial sequencer
  always_comb
  begin
    state_d        = state_q;
    cmd_d          = cmd_q;
    cnt_d          = cnt_q;
    ones_d         = ones_q;
    sh_d           = sh_q;
    mode_d         = mode_q;
    fhi_d          = fhi_q;
    flo_d          = flo_q;
    test_d         = test_q;
    cal_wr         = 1'b0;
    data_read_done = 1'b0;
    if (sclk_rise)
      ones_d = din ? ((ones_q == srs_pkg::QUIET_EDGES) ? ones_q : ones_q + 6'h01) : 6'h00;
    unique case (state_q)
      srs_pkg::ST_CMD:
      begin
        if (sclk_rise && !(cnt_q == 6'h00 && din))
        begin
          sh_d  = {sh_q[22:0], din};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'(srs_pkg::CMD_W - 1))
          begin
            cmd_d   = srs_pkg::srs_cmd_t'(sh_d[6:0]);
            cnt_d   = 6'h00;
            // a command that writes the command register is itself the next command
            if (cmd_d.sel != srs_pkg::RS_CMD || cmd_d.rd)
              state_d = srs_pkg::ST_LOAD;
          end
        end
      end
      srs_pkg::ST_LOAD:
      begin
        // one spare cycle lets the calibration read register follow the new channel
        unique case (cmd_q.sel)
          srs_pkg::RS_CMD:  sh_d = {rdy_low_q, cmd_q, 16'h0000};
          srs_pkg::RS_MODE: sh_d = {mode_q, 16'h0000};
          srs_pkg::RS_FHI:  sh_d = {fhi_q, 16'h0000};
          srs_pkg::RS_FLO:  sh_d = {flo_q, 16'h0000};
          srs_pkg::RS_TEST: sh_d = {test_q, 16'h0000};
          srs_pkg::RS_DATA: sh_d = fhi_q[srs_pkg::FHI_WL_BIT] ? data_q : {data_q[15:0], 8'h00};
          srs_pkg::RS_ZERO: sh_d = cal_zero;
          srs_pkg::RS_FULL: sh_d = cal_full;
        endcase
        // bit 7 of a command read carries the ready flag as its pin shows it
        state_d = cmd_q.rd ? srs_pkg::ST_READ : srs_pkg::ST_WRITE;
      end
      srs_pkg::ST_WRITE:
      begin
        if (sclk_rise)
        begin
          sh_d  = {sh_q[22:0], din};
          cnt_d = cnt_q + 6'h01;
          if (cnt_d == width)
          begin
            unique case (cmd_q.sel)
              srs_pkg::RS_MODE: mode_d = sh_d[7:0];
              srs_pkg::RS_FHI:  fhi_d  = sh_d[7:0];
              srs_pkg::RS_FLO:  flo_d  = sh_d[7:0];
              srs_pkg::RS_TEST: test_d = sh_d[7:0];
              srs_pkg::RS_ZERO, srs_pkg::RS_FULL: cal_wr = 1'b1;
              default: ;
            endcase
            cnt_d   = 6'h00;
            state_d = srs_pkg::ST_CMD;
          end
        end
      end
      srs_pkg::ST_READ:
      begin
        if (sclk_fall && cnt_q != 6'h00)
          sh_d = {sh_q[22:0], 1'b0};
        if (sclk_rise)
        begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_d == width)
          begin
            data_read_done = (cmd_q.sel == srs_pkg::RS_DATA);
            cnt_d          = 6'h00;
            state_d        = srs_pkg::ST_CMD;
          end
        end
      end
    endcase
    if (ones_d == srs_pkg::QUIET_EDGES)
    begin
      state_d = srs_pkg::ST_CMD;
      cnt_d   = 6'h00;
      cal_wr  = 1'b0;
    end
    dout_d = (state_d == srs_pkg::ST_READ) ? sh_d[23] : 1'b1;
  end

  // conversion result and ready flag; a new result wins over a read finishing
  always_comb
  begin
    conv_wr   = req.wr && !wait_q && req.addr == srs_pkg::AV_CONV;
    data_d    = data_q;
    rdy_low_d = rdy_low_q;
    if (data_read_done)
      rdy_low_d = 1'b1;
    if (conv_wr)
    begin
      for (int b = 0; b < 3; b++)
        if (req.be[b])
          data_d[8*b +: 8] = req.wdata[8*b +: 8];
      rdy_low_d = 1'b0;
    end
  end

  // avalon slave: waitrequest high on the first cycle, low on the second
  always_comb
  begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    if ((req.rd || req.wr) && wait_q)
    begin
      wait_d  = 1'b0;
      rdata_d = 32'h00000000;
      if (req.rd)
        unique case (req.addr)
          srs_pkg::AV_STATUS: rdata_d = {21'h000000, rdy_low_q, 2'(state_q), rdy_low_q, cmd_q};
          srs_pkg::AV_CONV:   rdata_d = {8'h00, data_q};
          srs_pkg::AV_CONFIG: rdata_d = {test_q, flo_q, fhi_q, mode_q};
          default:            rdata_d = 32'h00000000;
        endcase
    end
  end

  // serial side registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      state_q <= srs_pkg::ST_CMD;
      cmd_q   <= srs_pkg::srs_cmd_t'(srs_pkg::CMD_RESET);
      cnt_q   <= 6'h00;
      ones_q  <= 6'h00;
      sh_q    <= 24'h000000;
      dout_q  <= 1'b1;
      mode_q  <= srs_pkg::MODE_RESET;
      fhi_q   <= srs_pkg::FHI_RESET;
      flo_q   <= srs_pkg::FLO_RESET;
      test_q  <= srs_pkg::TEST_RESET;
    end
    else
    begin
      state_q <= state_d;
      cmd_q   <= cmd_d;
      cnt_q   <= cnt_d;
      ones_q  <= ones_d;
      sh_q    <= sh_d;
      dout_q  <= dout_d;
      mode_q  <= mode_d;
      fhi_q   <= fhi_d;
      flo_q   <= flo_d;
      test_q  <= test_d;
    end
  end

  // ready resets high so that no stale result looks new
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      rdy_low_q <= 1'b1;
      data_q    <= srs_pkg::DATA_RESET;
    end
    else
    begin
      rdy_low_q <= rdy_low_d;
      data_q    <= data_d;
    end
  end

  // bus answer registers; readdata holds until the next answer
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_dout                 = dout_q;
  assign o_conversion_ready_low = rdy_low_q;
  assign o_input_channel_select = cmd_q.chan;
  assign o_avs_readdata         = rdata_q;
  assign o_avs_waitrequest      = wait_q;
endmodule : srs_seq

/* testbench/srs_seq_checker.sv */
// checker: avalon handshake and serial pin relations of the sequencer
`timescale 1ns/10ps
module srs_seq_checker (
  input wire logic                          i_sys_clk,
  input wire logic                          i_reset,
  input wire logic                          i_sclk,
  input wire logic                          o_dout,
  input wire logic                          o_conversion_ready_low,
  input wire logic [2:0]                    o_input_channel_select,
  input wire logic [srs_pkg::AV_ADDR_W-1:0] i_avs_address,
  input wire logic                          i_avs_read,
  input wire logic                          i_avs_write,
  input wire logic [31:0]                   o_avs_readdata,
  input wire logic                          o_avs_waitrequest
);
  logic [3:0] hi_cnt_q;
  logic [3:0] hi_cnt_d;
  logic       req;
  logic       acc_rd;
  assign req    = i_avs_read || i_avs_write;
  assign acc_rd = i_avs_read && !o_avs_waitrequest;
  // sclk high longer than a half period means no frame is in flight
  always_comb
  begin
    hi_cnt_d = hi_cnt_q;
    if (!i_sclk)
      hi_cnt_d = 4'h0;
    else if (hi_cnt_q != 4'hF)
      hi_cnt_d = hi_cnt_q + 4'h1;
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      hi_cnt_q <= 4'h0;
    else
      hi_cnt_q <= hi_cnt_d;
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  chk_wait_answer: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("no answer one cycle after request");
  chk_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_wait_cause: assert property (!o_avs_waitrequest |-> $past(req))
    else $error("answer without request");
  chk_reset_pins: assert property (disable iff (1'b0) i_reset |=> o_dout && o_conversion_ready_low
    && o_input_channel_select == 3'h4 && o_avs_waitrequest) else $error("bad pin values after reset");
  chk_status_fmt: assert property (acc_rd && i_avs_address == srs_pkg::AV_STATUS |->
    o_avs_readdata[31:11] == 21'h0 && o_avs_readdata[10] == o_avs_readdata[7]) else $error("status format");
  chk_unmapped_zero: assert property (acc_rd && !(i_avs_address inside {4'h0, 4'h4, 4'h8}) |->
    o_avs_readdata == 32'h0) else $error("unmapped read not zero");
  chk_ready_write: assert property (i_avs_write && !o_avs_waitrequest && i_avs_address == srs_pkg::AV_CONV
    |=> !o_conversion_ready_low) else $error("ready not low after new result");
  chk_dout_idle: assert property (hi_cnt_q > 4'hB |-> o_dout)
    else $error("dout not high between frames");
  chk_chan_quiet: assert property (hi_cnt_q > 4'hB |-> $stable(o_input_channel_select))
    else $error("channel changed without serial traffic");
  cover property (i_avs_write && !o_avs_waitrequest);
  cover property ($fell(o_conversion_ready_low));
  cover property ($rose(o_conversion_ready_low));
endmodule : srs_seq_checker

/* testbench/srs_host_model.sv */
// host serial master model: makes sclk, drives din, samples dout
`timescale 1ns/10ps
module srs_host_model (
  output logic      o_sclk,
  output logic      o_din,
  input  wire logic i_dout
);
  initial
  begin
    o_sclk = 1'b1;
    o_din  = 1'b1;
  end
  // sclk stands high outside frames; odd offset keeps it off the system clock phase
  task automatic xfer(input int n, input logic [31:0] w, output logic [31:0] r);
    r = 32'h0;
    #1.3;
    for (int i = n - 1; i >= 0; i--)
    begin
      o_sclk = 1'b0;
      o_din  = w[i];
      #40;
      r[i]   = i_dout;
      o_sclk = 1'b1;
      #40;
    end
    o_din = ~o_din;
  endtask : xfer
  task automatic cmd_xfer(input logic [7:0] c, input int n, input logic [31:0] w, output logic [31:0] r);
    logic [31:0] q;
    xfer(8 + n, ({24'h0, c} << n) | w, q);
    r = q & ~(32'hFFFFFFFF << n);
  endtask : cmd_xfer
endmodule : srs_host_model

/* testbench/serial_register_access_sequencer_tb.sv */
// bench: avalon and serial host sequences with self-checks
`timescale 1ns/10ps
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin miscompares++; $display("BAD %0t %s", $time, m); end end
module serial_register_access_sequencer_tb;
  logic                i_sys_clk;
  logic                i_reset;
  logic                sclk;
  logic                din;
  logic                dout;
  logic                rdy_n;
  logic [2:0]          chan;
  srs_pkg::srs_avreq_t av;
  logic [31:0]         rdata;
  logic                wait_req;
  logic [31:0]         r;
  logic [7:0]          v [4];
  logic [7:0]          cw [3];
  logic [23:0]         cv [3];
  int                  miscompares;
  int                  n_compared;
  int                  cycles;
  srs_seq dut_u (
    .i_sys_clk              (i_sys_clk),
    .i_reset                (i_reset),
    .i_sclk                 (sclk),
    .i_din                  (din),
    .o_dout                 (dout),
    .o_conversion_ready_low (rdy_n),
    .o_input_channel_select (chan),
    .i_avs_address          (av.addr),
    .i_avs_read             (av.rd),
    .i_avs_write            (av.wr),
    .i_avs_writedata        (av.wdata),
    .i_avs_byteenable       (av.be),
    .o_avs_readdata         (rdata),
    .o_avs_waitrequest      (wait_req)
  );
  srs_host_model host_u (.o_sclk(sclk), .o_din(din), .i_dout(dout));
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  task automatic wrap_up;
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // waitrequest and readdata are read at the edge, before that edge's updates land
  task automatic av_io(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_sys_clk);
    av <= '{a, !w, w, d, 4'hF};
    do
    begin
      @(posedge i_sys_clk);
      k++;
    end while (wait_req !== 1'b0);
    r = rdata;
    av <= '0;
    `CHK(k, 2, "answer latency")
  endtask : av_io
  task automatic sx(input logic [7:0] c, input int n, input logic [31:0] w);
    host_u.cmd_xfer(c, n, w, r);
  endtask : sx
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  initial
  begin
    i_reset = 1'b1;
    av = '0;
    v = '{8'hA5, 8'h4F, 8'h3C, 8'h81};
    cw = '{8'h60, 8'h70, 8'h61};
    cv = '{24'h111111, 24'h222222, 24'h333333};
    repeat (5) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    `CHK({dout, rdy_n, chan}, 5'h1C, "reset pins")
    av_io(1'b0, srs_pkg::AV_STATUS, 32'h0);
    `CHK(r, 32'h00000484, "reset status")
    for (int i = 1; i < 5; i++)
      host_u.xfer(i == 1 ? 19 : 16, {13'h0, 3'h7, 1'b0, 3'(i), 4'h0, v[i-1]}, r);
    av_io(1'b0, srs_pkg::AV_CONFIG, 32'h0);
    `CHK(r, {v[3], v[2], v[1], v[0]}, "config")
    for (int i = 1; i < 5; i++)
    begin
      sx({1'b0, 3'(i), 4'hC}, 8, 32'h0);
      `CHK(r[7:0], v[i-1], "serial readback")
    end
    av_io(1'b1, srs_pkg::AV_CONV, 32'hAB123456);
    sx(8'h08, 8, 32'h0);
    `CHK({r[7:0], chan}, 11'h040, "ready in command")
    sx(8'h59, 24, 32'h0);
    `CHK({r, chan}, {32'h00123456, 3'h1}, "data read")
    sx(8'h08, 8, 32'h0);
    `CHK(r, 32'h00000088, "ready after read")
    sx(8'h50, 24, 32'h00654321);
    av_io(1'b0, srs_pkg::AV_CONV, 32'h0);
    `CHK(r, 32'h00123456, "data not writable")
    sx(8'h20, 8, 32'h0000000F);
    sx(8'h58, 16, 32'h0);
    `CHK(r, 32'h00003456, "short data")
    for (int i = 0; i < 3; i++)
      sx(cw[i], 24, {8'h0, cv[i]});
    for (int i = 0; i < 3; i++)
    begin
      sx(cw[i] | 8'h0C, 24, 32'h0);
      `CHK(r, {8'h0, cv[i]}, "calibration pair")
    end
    host_u.xfer(4, 32'h0, r);
    host_u.xfer(32, 32'hFFFFFFFF, r);
    av_io(1'b0, srs_pkg::AV_STATUS, 32'h0);
    `CHK(r[9:8], 2'h0, "abort to command wait")
    sx(8'h38, 8, 32'h0);
    `CHK(r, 32'h0000003C, "command after abort")
    av_io(1'b1, srs_pkg::AV_STATUS, 32'hFFFFFFFF);
    av_io(1'b1, srs_pkg::AV_CONFIG, 32'hFFFFFFFF);
    av_io(1'b0, srs_pkg::AV_CONFIG, 32'h0);
    `CHK(r, {v[3], v[2], 8'h0F, v[0]}, "config read only")
    av_io(1'b0, 4'hC, 32'h0);
    `CHK(r, 32'h0, "unmapped")
    av_io(1'b0, srs_pkg::AV_STATUS, 32'h0);
    `CHK(r[7:0], 8'hB8, "status after writes")
    wrap_up();
  end
endmodule : serial_register_access_sequencer_tb
bind srs_seq srs_seq_checker chk_u (
  .i_sys_clk,
  .i_reset,
  .i_sclk,
  .o_dout,
  .o_conversion_ready_low,
  .o_input_channel_select,
  .i_avs_address,
  .i_avs_read,
  .i_avs_write,
  .o_avs_readdata,
  .o_avs_waitrequest
);
